//--- include/hs_io_gpio_serdes_pkg.sv
// Constants, register map and mode encodings for the fast pad pair block.
// Assumes a 32-bit classic Wishbone slave port with word-aligned registers.
package hs_io_gpio_serdes_pkg;
   localparam int WORD_MAX = 10;
   localparam int GPIO_W = 4;
   localparam int DELAY_W = 6;
   localparam int DELAY_STEPS = 64;
   localparam int FIFO_WORDS = 8;
   localparam int ADR_W = 4;
   localparam int FACT_W = 4;
   localparam int QUIET_W = 5;
   localparam logic [QUIET_W-1:0] LOCK_COUNT = 5'h10;
   localparam logic [DELAY_W-1:0] DELAY_MIN = 6'h00;
   localparam logic [DELAY_W-1:0] DELAY_MAX = 6'h3f;

   // Register offsets
   localparam logic [ADR_W-1:0] CTRL_OFS = 4'h0;
   localparam logic [ADR_W-1:0] STAT_OFS = 4'h4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_8004;

   // Control field positions
   localparam int CTRL_DIFF = 0;
   localparam int CTRL_INMODE = 1;
   localparam int CTRL_RESYNC = 3;
   localparam int CTRL_OUTMODE = 4;
   localparam int CTRL_OEREG = 6;
   localparam int CTRL_HALF = 7;
   localparam int CTRL_FACT = 8;
   localparam int CTRL_FIFO = 12;
   localparam int CTRL_ALIGN = 13;
   localparam int CTRL_TERM = 14;
   localparam int CTRL_RXEN = 15;
   localparam int CTRL_DINIT = 16;

   // Status field positions
   localparam int STAT_DELAY = 0;
   localparam int STAT_EMPTY = 8;
   localparam int STAT_FULL = 9;
   localparam int STAT_LOCK = 10;
   localparam int STAT_COUNT = 11;

   // Synchroniser lanes
   localparam int S_ECLK = 0;
   localparam int S_ICLK = 1;
   localparam int S_ESER = 2;
   localparam int S_ISER = 3;
   localparam int S_PADP = 4;
   localparam int S_PADN = 5;
   localparam int S_LANES = 6;

   typedef enum logic [1:0] {
      IN_BYPASS = 2'b00,
      IN_REG = 2'b01,
      IN_DUAL = 2'b10,
      IN_DESER = 2'b11
   } in_mode_t;

   typedef enum logic [1:0] {
      OUT_REG = 2'b00,
      OUT_DUAL = 2'b01,
      OUT_SER = 2'b10,
      OUT_SPARE = 2'b11
   } out_mode_t;
endpackage

//--- src/hs_io_gpio_serdes.sv
// Fast pad pair I/O logic: dual-edge registers, serializer, deserializer,
// dynamic delay counter, phase alignment and receive FIFO.
// Assumes pad levels and all four core clocks arrive asynchronously.
// Contract
// - Pair works single-ended twice or differential once
// - Input bus bit0 normal, dual-edge bit1 falling
// - Output bus bit0 normal, dual-edge bit1 falling
// - Deserializer puts first bit at bit0
// - Serializer sends bit0 first, last bit last
// - Delay steps up or down while enabled
// - Clear returns delay counter to initial setting
// - Egress clock registers output, ingress clock input
// - Serial clocks drive serializer and deserializer
// - Bypass mode routes pad to alternate output
// - Serialization factor up to ten bits
// - Optional eight-word receive FIFO, receive only
// - Full rate transfers on serial rising edge
// - Half rate transfers on both serial edges
// - Phase alignment centres sampling, full rate only
// - Termination and input enable switch at runtime
// - Resync delays falling sample half a cycle
// - Sixty-four delay steps, input path only
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/10ps
module hs_io_gpio_serdes
   import hs_io_gpio_serdes_pkg::*;
#(
   parameter int WORD_W = WORD_MAX,
   parameter int FIFO_DEPTH = FIFO_WORDS
)
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic egressRegisterClock,
   input wire logic ingressRegisterClock,
   input wire logic egressSerialClock,
   input wire logic ingressSerialClock,
   input wire logic padInP,
   input wire logic padInN,
   output logic padOutP,
   output logic padOeP,
   output logic padOutN,
   output logic padOeN,
   input wire logic [WORD_W-1:0] coreOut,
   input wire logic coreOutN,
   input wire logic coreOe,
   input wire logic negativeSideOutputEnable,
   output logic [WORD_W-1:0] coreIn,
   output logic coreInN,
   output logic alternateBypassInput,
   input wire logic delayAdjustEnable,
   input wire logic delayStepDirection,
   input wire logic delayCounterClear,
   output logic [DELAY_W-1:0] delaySetting,
   output logic alignLock,
   input wire logic fifoRead,
   output logic [WORD_W-1:0] fifoWord,
   output logic fifoEmpty,
   output logic lvdsTermEnable,
   output logic lvdsInputEnable
);
   localparam int PTR_W = $clog2(FIFO_DEPTH);

   // Elaboration-time refusal of widths and depths the logic cannot serve
   if (WORD_W < GPIO_W || WORD_W > WORD_MAX || FIFO_DEPTH < 2 ||
       (1 << PTR_W) != FIFO_DEPTH || DELAY_STEPS != (1 << DELAY_W))
   begin
      $error("hs_io_gpio_serdes: unsupported parameter values");
   end

   function automatic logic [DELAY_W-1:0] stepDelay(input logic [DELAY_W-1:0] v,
                                                    input logic up);
      if (up)
         stepDelay = (v == DELAY_MAX) ? v : v + 6'h01;
      else
         stepDelay = (v == DELAY_MIN) ? v : v - 6'h01;
   endfunction

   // Synchronisers and edge detectors
   logic [S_LANES-1:0] syncAQ, syncBQ, syncCQ;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         syncAQ <= '0;
         syncBQ <= '0;
         syncCQ <= '0;
      end
      else
      begin
         syncAQ <= {padInN, padInP, ingressSerialClock, egressSerialClock,
                    ingressRegisterClock, egressRegisterClock};
         syncBQ <= syncAQ;
         syncCQ <= syncBQ;
      end
   end
   logic [S_LANES-1:0] riseE, fallE;
   assign riseE = syncBQ & ~syncCQ;
   assign fallE = ~syncBQ & syncCQ;

   // Register file
   logic [31:0] ctrl_q, ctrl_d, rdata_q, rdata_d, status;
   logic ack_q, ack_d;
   logic reqValid;
   assign reqValid = cyc_i & stb_i & ~ack_q;
   always_comb
   begin
      ctrl_d = ctrl_q;
      rdata_d = rdata_q;
      ack_d = reqValid;
      if (reqValid)
      begin
         rdata_d = 32'h0000_0000;
         if (we_i && adr_i == CTRL_OFS)
         begin
            for (int i = 0; i < 4; i++)
               if (sel_i[i])
                  ctrl_d[8*i +: 8] = dat_i[8*i +: 8];
         end
         else if (!we_i && adr_i == CTRL_OFS)
            rdata_d = ctrl_q;
         else if (!we_i && adr_i == STAT_OFS)
            rdata_d = status;
      end
   end
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         ctrl_q <= CTRL_RESET;
         rdata_q <= '0;
         ack_q <= 1'b0;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         rdata_q <= rdata_d;
         ack_q <= ack_d;
      end
   end
   assign dat_o = rdata_q;
   assign ack_o = ack_q;

   // Decoded configuration
   logic diffMode, resync, oeReg, halfRate, fifoOn, alignOn;
   logic [FACT_W-1:0] rawFactor, factor;
   in_mode_t inMode;
   out_mode_t outMode;
   assign diffMode = ctrl_q[CTRL_DIFF];
   assign inMode = in_mode_t'(ctrl_q[CTRL_INMODE +: 2]);
   assign resync = ctrl_q[CTRL_RESYNC];
   assign outMode = out_mode_t'(ctrl_q[CTRL_OUTMODE +: 2]);
   assign oeReg = ctrl_q[CTRL_OEREG];
   assign halfRate = ctrl_q[CTRL_HALF];
   assign fifoOn = ctrl_q[CTRL_FIFO];
   assign alignOn = ctrl_q[CTRL_ALIGN] & ~halfRate;
   assign rawFactor = ctrl_q[CTRL_FACT +: FACT_W];
   assign factor = (rawFactor == 4'h0 || 32'(rawFactor) > WORD_W) ?
                   FACT_W'(WORD_W) : rawFactor;
   assign lvdsTermEnable = ctrl_q[CTRL_TERM];
   assign lvdsInputEnable = ctrl_q[CTRL_RXEN];

   // Serial bit events: rising only at full rate, both edges at half rate
   logic iserEvt, eserEvt, rxP;
   assign iserEvt = riseE[S_ISER] | (halfRate & fallE[S_ISER]);
   assign eserEvt = riseE[S_ESER] | (halfRate & fallE[S_ESER]);
   assign rxP = syncBQ[S_PADP] & (~diffMode | lvdsInputEnable);

   // Input path
   logic [WORD_W-1:0] inWord_q, inWord_d, deserSh_q, deserSh_d, deserWord_q, deserWord_d;
   logic [FACT_W-1:0] deserIdx_q, deserIdx_d;
   logic fallHold_q, fallHold_d, deserRdy_q, deserRdy_d, inN_q, inN_d, alt_q, alt_d;
   logic push;
   always_comb
   begin
      inWord_d = inWord_q;
      deserSh_d = deserSh_q;
      deserWord_d = deserWord_q;
      deserIdx_d = deserIdx_q;
      fallHold_d = fallHold_q;
      deserRdy_d = deserRdy_q;
      inN_d = inN_q;
      alt_d = (inMode == IN_BYPASS) ? rxP : 1'b0;
      if (riseE[S_ICLK])
      begin
         unique case (inMode)
            IN_BYPASS: ;
            IN_REG: inWord_d = {{(WORD_W-1){1'b0}}, rxP};
            IN_DUAL:
            begin
               inWord_d[0] = rxP;
               if (resync)
                  inWord_d[1] = fallHold_q;
            end
            IN_DESER:
            begin
               if (deserRdy_q && !fifoOn)
                  inWord_d = deserWord_q;
               deserRdy_d = 1'b0;
            end
         endcase
         if (!diffMode && inMode != IN_BYPASS)
            inN_d = syncBQ[S_PADN];
      end
      if (fallE[S_ICLK] && inMode == IN_DUAL)
      begin
         fallHold_d = rxP;
         if (!resync)
            inWord_d[1] = rxP;
      end
      if (iserEvt && inMode == IN_DESER)
      begin
         deserSh_d[deserIdx_q] = rxP;
         if (deserIdx_q == factor - 4'h1)
         begin
            deserWord_d = deserSh_d;
            deserRdy_d = 1'b1;
            deserIdx_d = 4'h0;
         end
         else
            deserIdx_d = deserIdx_q + 4'h1;
      end
   end
   assign push = riseE[S_ICLK] & (inMode == IN_DESER) & deserRdy_q & fifoOn;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         inWord_q <= '0;
         deserSh_q <= '0;
         deserWord_q <= '0;
         deserIdx_q <= '0;
         fallHold_q <= 1'b0;
         deserRdy_q <= 1'b0;
         inN_q <= 1'b0;
         alt_q <= 1'b0;
      end
      else
      begin
         inWord_q <= inWord_d;
         deserSh_q <= deserSh_d;
         deserWord_q <= deserWord_d;
         deserIdx_q <= deserIdx_d;
         fallHold_q <= fallHold_d;
         deserRdy_q <= deserRdy_d;
         inN_q <= inN_d;
         alt_q <= alt_d;
      end
   end
   assign coreIn = inWord_q;
   assign coreInN = inN_q;
   assign alternateBypassInput = alt_q;

   // Output path, never delayed by the dynamic chain
   logic [WORD_W-1:0] outSh_q, outSh_d;
   logic [FACT_W-1:0] outIdx_q, outIdx_d;
   logic outP_q, outP_d, outLo_q, outLo_d, oeP_q, oeP_d, outN_q, outN_d, oeN_q, oeN_d;
   always_comb
   begin
      outSh_d = outSh_q;
      outIdx_d = outIdx_q;
      outP_d = outP_q;
      outLo_d = outLo_q;
      oeP_d = oeP_q;
      outN_d = outN_q;
      oeN_d = oeN_q;
      if (eserEvt && outMode == OUT_SER)
      begin
         outP_d = outSh_q[outIdx_q];
         outIdx_d = (outIdx_q == factor - 4'h1) ? 4'h0 : outIdx_q + 4'h1;
      end
      if (riseE[S_ECLK])
      begin
         unique case (outMode)
            OUT_REG: outP_d = coreOut[0];
            OUT_DUAL:
            begin
               outP_d = coreOut[0];
               outLo_d = coreOut[1];
            end
            OUT_SER:
            begin
               outSh_d = coreOut;
               outIdx_d = 4'h0;
            end
            OUT_SPARE: ;
         endcase
         if (!diffMode)
            outN_d = coreOutN;
      end
      if (fallE[S_ECLK] && outMode == OUT_DUAL)
         outP_d = outLo_q;
      if (!oeReg || riseE[S_ECLK])
      begin
         oeP_d = coreOe;
         oeN_d = negativeSideOutputEnable;
      end
      if (diffMode)
         outN_d = ~outP_d;
   end
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         outSh_q <= '0;
         outIdx_q <= '0;
         outP_q <= 1'b0;
         outLo_q <= 1'b0;
         oeP_q <= 1'b0;
         outN_q <= 1'b0;
         oeN_q <= 1'b0;
      end
      else
      begin
         outSh_q <= outSh_d;
         outIdx_q <= outIdx_d;
         outP_q <= outP_d;
         outLo_q <= outLo_d;
         oeP_q <= oeP_d;
         outN_q <= outN_d;
         oeN_q <= oeN_d;
      end
   end
   assign padOutP = outP_q;
   assign padOeP = oeP_q;
   assign padOutN = outN_q;
   assign padOeN = oeN_q;

   // Delay counter and phase alignment
   logic [DELAY_W-1:0] delay_q, delay_d;
   logic [QUIET_W-1:0] quiet_q, quiet_d;
   logic lock_q, lock_d, probe_q, probe_d, early_q, early_d, sample_q, sample_d;
   logic prev_q, prev_d;
   always_comb
   begin
      delay_d = delay_q;
      quiet_d = quiet_q;
      lock_d = lock_q;
      probe_d = 1'b0;
      early_d = early_q;
      sample_d = sample_q;
      prev_d = rxP;
      if (delayCounterClear)
      begin
         delay_d = ctrl_q[CTRL_DINIT +: DELAY_W];
         quiet_d = '0;
         lock_d = 1'b0;
      end
      else if (alignOn)
      begin
         if (probe_q)
         begin
            if (rxP != sample_q)
               delay_d = stepDelay(delay_q, 1'b0);
            if (early_q || rxP != sample_q)
               quiet_d = '0;
            else if (quiet_q != LOCK_COUNT)
               quiet_d = quiet_q + 5'h01;
            lock_d = (quiet_d == LOCK_COUNT);
         end
         if (iserEvt)
         begin
            sample_d = rxP;
            probe_d = 1'b1;
            early_d = (prev_q != rxP);
            if (prev_q != rxP)
               delay_d = stepDelay(delay_q, 1'b1);
         end
      end
      else if (delayAdjustEnable && riseE[S_ICLK])
         delay_d = stepDelay(delay_q, delayStepDirection);
   end
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         delay_q <= DELAY_MIN;
         quiet_q <= '0;
         lock_q <= 1'b0;
         probe_q <= 1'b0;
         early_q <= 1'b0;
         sample_q <= 1'b0;
         prev_q <= 1'b0;
      end
      else
      begin
         delay_q <= delay_d;
         quiet_q <= quiet_d;
         lock_q <= lock_d;
         probe_q <= probe_d;
         early_q <= early_d;
         sample_q <= sample_d;
         prev_q <= prev_d;
      end
   end
   assign delaySetting = delay_q;
   assign alignLock = lock_q;

   // Receive FIFO
   logic [WORD_W-1:0] fifoMem [FIFO_DEPTH];
   logic [PTR_W-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
   logic [PTR_W:0] count_q, count_d;
   logic [WORD_W-1:0] fword_q, fword_d;
   logic empty_q, empty_d, doPush, doPop;
   assign doPush = push && (count_q != (PTR_W+1)'(FIFO_DEPTH));
   assign doPop = fifoRead && (count_q != '0);
   always_comb
   begin
      wrPtr_d = doPush ? wrPtr_q + 1'b1 : wrPtr_q;
      rdPtr_d = doPop ? rdPtr_q + 1'b1 : rdPtr_q;
      fword_d = doPop ? fifoMem[rdPtr_q] : fword_q;
      count_d = count_q + (PTR_W+1)'(doPush) - (PTR_W+1)'(doPop);
      empty_d = (count_d == '0);
   end
   always_ff @(posedge clock)
   begin
      if (doPush)
         fifoMem[wrPtr_q] <= deserWord_q;
   end
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
         fword_q <= '0;
         empty_q <= 1'b1;
      end
      else
      begin
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
         count_q <= count_d;
         fword_q <= fword_d;
         empty_q <= empty_d;
      end
   end
   assign fifoWord = fword_q;
   assign fifoEmpty = empty_q;

   // Status readback
   always_comb
   begin
      status = 32'h0000_0000;
      status[STAT_DELAY +: DELAY_W] = delay_q;
      status[STAT_EMPTY] = empty_q;
      status[STAT_FULL] = (count_q == (PTR_W+1)'(FIFO_DEPTH));
      status[STAT_LOCK] = lock_q;
      status[STAT_COUNT +: PTR_W+1] = count_q;
   end
endmodule

//--- verif/core_clock_model.sv
// Core-side partner: makes register and serial clocks and output enables.
// Assumes the system clock runs far faster than the clocks it makes.
`timescale 1ns/10ps
module core_clock_model
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic run,
   input wire logic oe,
   output logic regClk,
   output logic serClk,
   output logic oeP,
   output logic negative_side_output_enable
);
   logic running_d, running_q;
   logic [4:0] cnt_d, cnt_q;

   always_comb
   begin
      running_d = run;
      cnt_d = running_q ? cnt_q + 5'h01 : 5'h10;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         running_q <= 1'b0;
         cnt_q <= 5'h10;
      end
      else
      begin
         running_q <= running_d;
         cnt_q <= cnt_d;
      end
   end

   // Four serial periods per register period, one bit each; still when idle
   assign serClk = running_q & cnt_q[2];
   assign regClk = running_q & cnt_q[4];
   // Negative-side enable copies the primary one
   assign oeP = oe;
   assign negative_side_output_enable = oe;
endmodule

//--- verif/hs_io_gpio_serdes_monitor.sv
// Checker for the fast pad pair block: bus handshake, delay counter, FIFO flag.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module hs_io_gpio_serdes_monitor
   import hs_io_gpio_serdes_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic delayCounterClear,
   input wire logic [DELAY_W-1:0] delaySetting,
   input wire logic fifoRead,
   input wire logic fifoEmpty
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   // Bus request taken, and clear held over two cycles
   sequence busReq;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence clearHeld;
      delayCounterClear [*2];
   endsequence

   ack_latency_a: assert property (busReq |=> ack_o)
      else $error("bus request not answered next cycle");
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack held for two cycles");
   ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without a request");
   zero_data_a: assert property (
      ack_o && $past(we_i || (adr_i != CTRL_OFS && adr_i != STAT_OFS)) |-> dat_o == 32'h0)
      else $error("write or unmapped read returned data");
   status_view_a: assert property (
      ack_o && $past(!we_i && adr_i == STAT_OFS)
      |-> dat_o[5:0] == $past(delaySetting) && dat_o[8] == $past(fifoEmpty))
      else $error("status read disagrees with delay or empty flag");
   delay_step_a: assert property (
      !$past(delayCounterClear)
      |-> 6'(delaySetting - $past(delaySetting)) inside {6'h00, 6'h01, 6'h3f})
      else $error("delay moved by more than one step");
   no_wrap_up_a: assert property (
      $past(delaySetting) == DELAY_MAX && !$past(delayCounterClear) |-> delaySetting != DELAY_MIN)
      else $error("delay wrapped past maximum");
   no_wrap_down_a: assert property (
      $past(delaySetting) == DELAY_MIN && !$past(delayCounterClear) |-> delaySetting != DELAY_MAX)
      else $error("delay wrapped past minimum");
   clear_priority_a: assert property (clearHeld |=> $stable(delaySetting))
      else $error("delay moved while clear held");
   empty_after_pop_a: assert property ($rose(fifoEmpty) |-> $past(fifoRead))
      else $error("fifo emptied without a pop");
endmodule

//--- verif/tb.sv
// Self-checking bench: registers, GPIO modes, serializer, FIFO, delay counter.
// Assumes the clock model and the checker are compiled before it.
`timescale 1ns/10ps
module tb
   import hs_io_gpio_serdes_pkg::*;
;
   logic clock, rstn, cyc_i, stb_i, we_i, run, oe, fifoRead, padInP;
   logic padInN, coreOutN, coreInN, alignLock;
   logic delayAdjustEnable, delayStepDirection, delayCounterClear;
   logic [ADR_W-1:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o, rd;
   logic [WORD_MAX-1:0] coreOut, coreIn, fifoWord;
   logic ack_o, padOutP, padOeP, padOutN, padOeN, alternateBypassInput, fifoEmpty;
   logic lvdsTermEnable, lvdsInputEnable, regClk, serClk, oeP, negative_side_output_enable;
   logic [DELAY_W-1:0] delaySetting;
   int n_fail = 0;
   int num_checks = 0;

   core_clock_model partner (.clock, .rstn, .run, .oe, .regClk, .serClk, .oeP, .negative_side_output_enable);
   hs_io_gpio_serdes dut (.clock, .rstn, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i,
      .dat_o, .ack_o, .egressRegisterClock(regClk), .ingressRegisterClock(regClk),
      .egressSerialClock(serClk), .ingressSerialClock(serClk), .padInP, .padInN,
      .padOutP, .padOeP, .padOutN, .padOeN, .coreOut, .coreOutN, .coreOe(oeP),
      .negativeSideOutputEnable(negative_side_output_enable), .coreIn, .coreInN, .alternateBypassInput,
      .delayAdjustEnable, .delayStepDirection, .delayCounterClear, .delaySetting,
      .alignLock, .fifoRead, .fifoWord, .fifoEmpty, .lvdsTermEnable, .lvdsInputEnable);

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      $display("checks=%0d failures=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // One classic cycle, entered just after a rising edge
   task automatic wbCycle(input logic [ADR_W-1:0] a, input logic w, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] q);
      adr_i <= a;
      we_i <= w;
      dat_i <= d;
      sel_i <= s;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      do @(posedge clock); while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clock);
   endtask

   task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
      logic [31:0] q;
      wbCycle(a, 1'b1, d, 4'hf, q);
   endtask

   task automatic rdChk(input logic [ADR_W-1:0] a, input logic [31:0] exp);
      wbCycle(a, 1'b0, 32'h0, 4'hf, rd);
      check(rd, exp);
   endtask

   // Run the register clock for n rising edges, then stop it
   task automatic steps(input int n);
      run <= 1'b1;
      repeat (n) @(posedge regClk);
      repeat (6) @(posedge clock);
      run <= 1'b0;
      repeat (4) @(posedge clock);
   endtask

   task automatic clr;
      delayCounterClear <= 1'b1;
      repeat (2) @(posedge clock);
      delayCounterClear <= 1'b0;
      @(posedge clock);
   endtask

   initial
   begin
      #100000;
      n_fail++;
      wrap_up;
   end

   initial
   begin
      rstn = 1'b0;
      {cyc_i, stb_i, we_i, run, oe, fifoRead, padInP, padInN, coreOutN} = 9'h000;
      {delayAdjustEnable, delayStepDirection, delayCounterClear} = 3'h0;
      adr_i = 4'h0;
      sel_i = 4'hf;
      dat_i = 32'h0;
      coreOut = 10'h000;
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      // Reset values, refused writes, unmapped read
      rdChk(CTRL_OFS, CTRL_RESET);
      rdChk(STAT_OFS, 32'h0000_0100);
      rdChk(4'h8, 32'h0);
      wr(STAT_OFS, 32'hffff_ffff);
      wbCycle(CTRL_OFS, 1'b1, 32'hffff_ffff, 4'h0, rd);
      rdChk(STAT_OFS, 32'h0000_0100);
      rdChk(CTRL_OFS, CTRL_RESET);
      // Termination on, input buffer off, input bypass
      wr(CTRL_OFS, 32'h0000_4000);
      repeat (2) @(posedge clock);
      check(lvdsTermEnable, 1'b1);
      check(lvdsInputEnable, 1'b0);
      padInP <= 1'b1;
      repeat (5) @(posedge clock);
      check(alternateBypassInput, 1'b1);
      padInP <= 1'b0;
      repeat (5) @(posedge clock);
      check(alternateBypassInput, 1'b0);
      // Differential dual-edge in and out
      wr(CTRL_OFS, 32'h0000_8015);
      coreOut <= 10'h001;
      padInP <= 1'b1;
      oe <= 1'b1;
      run <= 1'b1;
      @(posedge regClk);
      repeat (4) @(posedge clock);
      check(padOutP, 1'b1);
      check(padOutN, 1'b0);
      padInP <= 1'b0;
      @(negedge regClk);
      repeat (4) @(posedge clock);
      check(padOutP, 1'b0);
      check(padOutN, 1'b1);
      check(coreIn[1:0], 2'b01);
      check({padOeP, padOeN}, 2'b11);
      run <= 1'b0;
      repeat (4) @(posedge clock);
      // Factor four serializer and deserializer into the FIFO
      wr(CTRL_OFS, 32'h0000_9426);
      coreOut <= 10'h00d;
      run <= 1'b1;
      @(posedge regClk);
      padInP <= ~coreOut[0];
      for (int i = 0; i < 4; i++)
      begin
         @(posedge serClk);
         repeat (4) @(posedge clock);
         check(padOutP, coreOut[i]);
         padInP <= ~coreOut[i+1];
      end
      repeat (8) @(posedge clock);
      run <= 1'b0;
      check(fifoEmpty, 1'b0);
      fifoRead <= 1'b1;
      @(posedge clock);
      fifoRead <= 1'b0;
      @(posedge clock);
      check(fifoWord[3:0], 4'h2);
      check(fifoEmpty, 1'b1);
      // Single-ended resync input, registered enable, N side
      wr(CTRL_OFS, 32'h0000_804c);
      {padInN, coreOutN, oe} <= 3'b110;
      padInP <= 1'b1;
      repeat (4) @(posedge clock);
      check(padOeP, 1'b1);
      steps(2);
      check({padOeP, padOutN, coreInN}, 3'b011);
      check(coreIn[1:0], 2'b11);
      padInP <= 1'b0;
      steps(1);
      repeat (2) @(posedge clock);
      check(coreIn[1:0], 2'b10);
      // Delay counter: clear, step, saturate
      wr(CTRL_OFS, 32'h003d_8004);
      clr;
      check(delaySetting, 6'h3d);
      delayAdjustEnable <= 1'b1;
      delayStepDirection <= 1'b1;
      steps(3);
      check(delaySetting, DELAY_MAX);
      delayStepDirection <= 1'b0;
      steps(2);
      check(delaySetting, 6'h3d);
      delayAdjustEnable <= 1'b0;
      steps(2);
      check(delaySetting, 6'h3d);
      wr(CTRL_OFS, 32'h0001_8004);
      clr;
      delayAdjustEnable <= 1'b1;
      steps(3);
      check(delaySetting, DELAY_MIN);
      rdChk(STAT_OFS, 32'h0000_0100);
      // Auto alignment locks on a quiet line and overrides manual steps
      wr(CTRL_OFS, 32'h0000_a004);
      delayStepDirection <= 1'b1;
      steps(6);
      check({alignLock, delaySetting}, {1'b1, DELAY_MIN});
      rdChk(STAT_OFS, 32'h0000_0500);
      wrap_up;
   end
endmodule

bind hs_io_gpio_serdes hs_io_gpio_serdes_monitor mon (.clock, .rstn, .cyc_i, .stb_i,
   .we_i, .adr_i, .dat_o, .ack_o, .delayCounterClear, .delaySetting, .fifoRead, .fifoEmpty);
